// *** common/clc_pkg.sv ***
package clc_pkg;

   // ----------------------------------------
   // bus geometry and register map
   // ----------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [7:0] OFF_CONTROL = 8'h00;
   localparam logic [7:0] OFF_POLARITY = 8'h04;
   localparam logic [7:0] OFF_SRC1 = 8'h08;
   localparam logic [7:0] OFF_SRC2 = 8'h0C;
   localparam logic [7:0] OFF_SRC3 = 8'h10;
   localparam logic [7:0] OFF_SRC4 = 8'h14;
   localparam logic [7:0] OFF_GATE1 = 8'h18;
   localparam logic [7:0] OFF_GATE2 = 8'h1C;
   localparam logic [7:0] OFF_GATE3 = 8'h20;
   localparam logic [7:0] OFF_GATE4 = 8'h24;
   localparam logic [7:0] OFF_STATUS = 8'h28;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ----------------------------------------
   // fields and reset values
   // ----------------------------------------
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam int POL_OUT_BIT = 7;
   localparam int STATUS_FLAG_BIT = 0;
   localparam int SEL_W = 6;
   localparam int GATE_COUNT = 4;
   localparam int SYNC_STAGES = 2;

   typedef enum logic [2:0] {
      FUNC_AND_OR = 3'b000,
      FUNC_OR_XOR = 3'b001,
      FUNC_AND = 3'b010,
      FUNC_SR = 3'b011,
      FUNC_D_SR = 3'b100,
      FUNC_D_R = 3'b101,
      FUNC_JK_R = 3'b110,
      FUNC_LATCH_SR = 3'b111
   } clc_func_t;

   typedef struct packed {
      logic cell_on;
      logic unused;
      logic cell_result;
      logic rise_irq_on;
      logic fall_irq_on;
      clc_func_t function_select;
   } clc_ctrl_t;

endpackage

// *** verilog/clc_sync.sv ***
`timescale 1ns/1ns
module clc_sync #(
   parameter int WIDTH = 64
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   // ----------------------------------------
   // two-flop synchroniser
   // ----------------------------------------
   // first stage feeds only the second one
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] meta_next;
   logic [WIDTH-1:0] sync_reg;
   logic [WIDTH-1:0] sync_next;

   always_comb begin
      meta_next = async_in;
      sync_next = meta_reg;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
      end
   end

   assign sync_out = sync_reg;

endmodule

// *** verilog/clc_gate.sv ***
`timescale 1ns/1ns
module clc_gate (
   input wire logic [3:0] data,
   input wire logic [7:0] terms,
   input wire logic invert,
   output logic gate_out
);

   // ----------------------------------------
   // one data gate
   // ----------------------------------------
   logic [3:0] pass;
   logic any_term;

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         // odd bit true term, even bit negated term
         pass[i] = (~terms[2*i+1] | data[i]) & (~terms[2*i] | ~data[i]);
      end
      any_term = |terms;
      // empty gate: level set by inversion alone
      gate_out = (any_term & (&pass)) ^ invert;
   end

endmodule

// *** verilog/clc_cell.sv ***
// Local design decisions: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ns
module clc_cell #(
   parameter int SRC_COUNT = 64
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [clc_pkg::ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [clc_pkg::DATA_W-1:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [clc_pkg::ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [clc_pkg::DATA_W-1:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic [SRC_COUNT-1:0] source_in,
   output logic cell_output_signal,
   output logic cell_irq_flag
);

   // ----------------------------------------
   // elaboration check
   // ----------------------------------------
   // six select bits reach at most 64 sources
   if (SRC_COUNT < 1 || SRC_COUNT > 64) begin : g_bad_count
      $error("clc_cell: SRC_COUNT must be 1 to 64");
   end

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   logic aw_hold_reg;
   logic aw_hold_next;
   logic [clc_pkg::ADDR_W-1:0] aw_addr_reg;
   logic [clc_pkg::ADDR_W-1:0] aw_addr_next;
   logic w_hold_reg;
   logic w_hold_next;
   logic [7:0] w_byte_reg;
   logic [7:0] w_byte_next;
   logic w_lane_reg;
   logic w_lane_next;
   logic bvalid_reg;
   logic bvalid_next;
   logic [1:0] bresp_reg;
   logic [1:0] bresp_next;
   logic rvalid_reg;
   logic rvalid_next;
   logic [1:0] rresp_reg;
   logic [1:0] rresp_next;
   logic [clc_pkg::DATA_W-1:0] rdata_reg;
   logic [clc_pkg::DATA_W-1:0] rdata_next;
   logic do_write;
   logic wr_hit;
   logic rd_hit;
   logic [7:0] rd_byte;

   clc_pkg::clc_ctrl_t ctrl_reg;
   clc_pkg::clc_ctrl_t ctrl_next;
   logic out_invert_reg;
   logic out_invert_next;
   logic [3:0] gate_invert_reg;
   logic [3:0] gate_invert_next;
   logic [clc_pkg::SEL_W-1:0] src_sel_reg [4];
   logic [clc_pkg::SEL_W-1:0] src_sel_next [4];
   logic [7:0] gate_terms_reg [4];
   logic [7:0] gate_terms_next [4];

   logic [SRC_COUNT-1:0] src_sync;
   logic [3:0] data_in;
   logic [3:0] gate_val;
   logic clk_prev_reg;
   logic clk_prev_next;
   logic state_reg;
   logic state_next;
   logic out_reg;
   logic out_next;
   logic flag_reg;
   logic flag_next;
   logic logic_value;
   logic clk_rise;
   logic set_in;
   logic rst_in;
   logic rise_evt;
   logic fall_evt;
   logic flag_clear;

   // ----------------------------------------
   // axi4-lite write channel
   // ----------------------------------------
   assign awready = ~aw_hold_reg & ~bvalid_reg;
   assign wready = ~w_hold_reg & ~bvalid_reg;
   assign bvalid = bvalid_reg;
   assign bresp = bresp_reg;

   always_comb begin
      unique case ({aw_addr_reg[7:2], 2'b00})
         clc_pkg::OFF_CONTROL,
         clc_pkg::OFF_POLARITY,
         clc_pkg::OFF_SRC1,
         clc_pkg::OFF_SRC2,
         clc_pkg::OFF_SRC3,
         clc_pkg::OFF_SRC4,
         clc_pkg::OFF_GATE1,
         clc_pkg::OFF_GATE2,
         clc_pkg::OFF_GATE3,
         clc_pkg::OFF_GATE4,
         clc_pkg::OFF_STATUS: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   always_comb begin
      aw_hold_next = aw_hold_reg;
      aw_addr_next = aw_addr_reg;
      w_hold_next = w_hold_reg;
      w_byte_next = w_byte_reg;
      w_lane_next = w_lane_reg;
      bvalid_next = bvalid_reg;
      bresp_next = bresp_reg;
      // both halves present and no answer pending
      do_write = aw_hold_reg & w_hold_reg & ~bvalid_reg;
      if (awvalid && awready) begin
         aw_hold_next = 1'b1;
         aw_addr_next = awaddr;
      end
      if (wvalid && wready) begin
         w_hold_next = 1'b1;
         w_byte_next = wdata[7:0];
         w_lane_next = wstrb[0];
      end
      if (do_write) begin
         aw_hold_next = 1'b0;
         w_hold_next = 1'b0;
         bvalid_next = 1'b1;
         bresp_next = wr_hit ? clc_pkg::RESP_OKAY : clc_pkg::RESP_SLVERR;
      end else if (bvalid_reg && bready) begin
         bvalid_next = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_reg <= 1'b0;
         aw_addr_reg <= '0;
         w_hold_reg <= 1'b0;
         w_byte_reg <= '0;
         w_lane_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= clc_pkg::RESP_OKAY;
      end else begin
         aw_hold_reg <= aw_hold_next;
         aw_addr_reg <= aw_addr_next;
         w_hold_reg <= w_hold_next;
         w_byte_reg <= w_byte_next;
         w_lane_reg <= w_lane_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
      end
   end

   // ----------------------------------------
   // control register
   // ----------------------------------------
   // registers are 8 bits wide: only byte lane 0 stores
   always_comb begin
      ctrl_next = ctrl_reg;
      if (do_write && w_lane_reg &&
          {aw_addr_reg[7:2], 2'b00} == clc_pkg::OFF_CONTROL) begin
         ctrl_next = clc_pkg::clc_ctrl_t'(w_byte_reg);
      end
      ctrl_next.unused = 1'b0;
      ctrl_next.cell_result = 1'b0;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg <= clc_pkg::clc_ctrl_t'(clc_pkg::CTRL_RESET);
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   // ----------------------------------------
   // polarity, source and gate registers
   // ----------------------------------------
   // no reset here: source, gate and gate-inversion settings survive every reset
   always_comb begin
      out_invert_next = out_invert_reg;
      gate_invert_next = gate_invert_reg;
      src_sel_next = src_sel_reg;
      gate_terms_next = gate_terms_reg;
      if (do_write && w_lane_reg) begin
         unique case ({aw_addr_reg[7:2], 2'b00})
            clc_pkg::OFF_POLARITY: begin
               out_invert_next = w_byte_reg[clc_pkg::POL_OUT_BIT];
               gate_invert_next = w_byte_reg[3:0];
            end
            clc_pkg::OFF_SRC1: src_sel_next[0] = w_byte_reg[5:0];
            clc_pkg::OFF_SRC2: src_sel_next[1] = w_byte_reg[5:0];
            clc_pkg::OFF_SRC3: src_sel_next[2] = w_byte_reg[5:0];
            clc_pkg::OFF_SRC4: src_sel_next[3] = w_byte_reg[5:0];
            clc_pkg::OFF_GATE1: gate_terms_next[0] = w_byte_reg;
            clc_pkg::OFF_GATE2: gate_terms_next[1] = w_byte_reg;
            clc_pkg::OFF_GATE3: gate_terms_next[2] = w_byte_reg;
            clc_pkg::OFF_GATE4: gate_terms_next[3] = w_byte_reg;
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      gate_invert_reg <= gate_invert_next;
      src_sel_reg <= src_sel_next;
      gate_terms_reg <= gate_terms_next;
   end

   // output inversion resets to zero, unlike the gate settings
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         out_invert_reg <= 1'b0;
      end else begin
         out_invert_reg <= out_invert_next;
      end
   end

   // ----------------------------------------
   // axi4-lite read channel
   // ----------------------------------------
   assign arready = ~rvalid_reg;
   assign rvalid = rvalid_reg;
   assign rdata = rdata_reg;
   assign rresp = rresp_reg;

   always_comb begin
      rd_hit = 1'b1;
      rd_byte = 8'h00;
      unique case ({araddr[7:2], 2'b00})
         clc_pkg::OFF_CONTROL: begin
            rd_byte = ctrl_reg;
            rd_byte[5] = out_reg;
         end
         clc_pkg::OFF_POLARITY:
            rd_byte = {out_invert_reg, 3'b000, gate_invert_reg};
         clc_pkg::OFF_SRC1: rd_byte = {2'b00, src_sel_reg[0]};
         clc_pkg::OFF_SRC2: rd_byte = {2'b00, src_sel_reg[1]};
         clc_pkg::OFF_SRC3: rd_byte = {2'b00, src_sel_reg[2]};
         clc_pkg::OFF_SRC4: rd_byte = {2'b00, src_sel_reg[3]};
         clc_pkg::OFF_GATE1: rd_byte = gate_terms_reg[0];
         clc_pkg::OFF_GATE2: rd_byte = gate_terms_reg[1];
         clc_pkg::OFF_GATE3: rd_byte = gate_terms_reg[2];
         clc_pkg::OFF_GATE4: rd_byte = gate_terms_reg[3];
         clc_pkg::OFF_STATUS: rd_byte = {7'h00, flag_reg};
         default: rd_hit = 1'b0;
      endcase
   end

   always_comb begin
      rvalid_next = rvalid_reg;
      rdata_next = rdata_reg;
      rresp_next = rresp_reg;
      if (arvalid && arready) begin
         rvalid_next = 1'b1;
         rdata_next = {24'h00_0000, rd_byte};
         rresp_next = rd_hit ? clc_pkg::RESP_OKAY : clc_pkg::RESP_SLVERR;
      end else if (rvalid_reg && rready) begin
         rvalid_next = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= '0;
         rresp_reg <= clc_pkg::RESP_OKAY;
      end else begin
         rvalid_reg <= rvalid_next;
         rdata_reg <= rdata_next;
         rresp_reg <= rresp_next;
      end
   end

   // ----------------------------------------
   // data selection and gating
   // ----------------------------------------
   // sources run off other clocks and pins: sample them first
   clc_sync #(
      .WIDTH(SRC_COUNT)
   ) u_src_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .async_in(source_in),
      .sync_out(src_sync)
   );

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         // codes beyond the source count read as low
         if (int'(src_sel_reg[i]) < SRC_COUNT) begin
            data_in[i] = src_sync[src_sel_reg[i]];
         end else begin
            data_in[i] = 1'b0;
         end
      end
   end

   for (genvar g = 0; g < clc_pkg::GATE_COUNT; g++) begin : g_gate
      clc_gate u_gate (
         .data(data_in),
         .terms(gate_terms_reg[g]),
         .invert(gate_invert_reg[g]),
         .gate_out(gate_val[g])
      );
   end

   // ----------------------------------------
   // logic function
   // ----------------------------------------
   // flop modes step on aclk, so gate clocks must run no faster
   // than half the system clock to be seen
   always_comb begin
      clk_rise = gate_val[0] & ~clk_prev_reg;
      clk_prev_next = gate_val[0];
      set_in = gate_val[3];
      rst_in = gate_val[2];
      state_next = state_reg;
      logic_value = 1'b0;
      unique case (ctrl_reg.function_select)
         clc_pkg::FUNC_AND_OR:
            logic_value = (gate_val[0] & gate_val[1]) |
                          (gate_val[2] & gate_val[3]);
         clc_pkg::FUNC_OR_XOR:
            logic_value = (gate_val[0] | gate_val[1]) ^
                          (gate_val[2] | gate_val[3]);
         clc_pkg::FUNC_AND:
            logic_value = &gate_val;
         clc_pkg::FUNC_SR: begin
            // set side wins when both are high
            if (gate_val[0] | gate_val[1]) begin
               state_next = 1'b1;
            end else if (gate_val[2] | gate_val[3]) begin
               state_next = 1'b0;
            end
            logic_value = state_next;
         end
         clc_pkg::FUNC_D_SR: begin
            if (rst_in) begin
               state_next = 1'b0;
            end else if (set_in) begin
               state_next = 1'b1;
            end else if (clk_rise) begin
               state_next = gate_val[1];
            end
            logic_value = state_next;
         end
         clc_pkg::FUNC_D_R: begin
            if (rst_in) begin
               state_next = 1'b0;
            end else if (clk_rise) begin
               state_next = gate_val[1] & gate_val[3];
            end
            logic_value = state_next;
         end
         clc_pkg::FUNC_JK_R: begin
            if (rst_in) begin
               state_next = 1'b0;
            end else if (clk_rise) begin
               unique case ({gate_val[1], gate_val[3]})
                  2'b00: state_next = state_reg;
                  2'b01: state_next = 1'b0;
                  2'b10: state_next = 1'b1;
                  2'b11: state_next = ~state_reg;
               endcase
            end
            logic_value = state_next;
         end
         clc_pkg::FUNC_LATCH_SR: begin
            // transparent while gate 1 is low
            if (rst_in) begin
               state_next = 1'b0;
            end else if (set_in) begin
               state_next = 1'b1;
            end else if (!gate_val[0]) begin
               state_next = gate_val[1];
            end
            logic_value = state_next;
         end
      endcase
      if (!ctrl_reg.cell_on) begin
         state_next = 1'b0;
      end
      // disabled cell drives zero whatever the polarity
      out_next = ctrl_reg.cell_on & (logic_value ^ out_invert_reg);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clk_prev_reg <= 1'b0;
         state_reg <= 1'b0;
         out_reg <= 1'b0;
      end else begin
         clk_prev_reg <= clk_prev_next;
         state_reg <= state_next;
         out_reg <= out_next;
      end
   end

   assign cell_output_signal = out_reg;

   // ----------------------------------------
   // edge detectors and sticky flag
   // ----------------------------------------
   always_comb begin
      rise_evt = ctrl_reg.rise_irq_on & out_next & ~out_reg;
      fall_evt = ctrl_reg.fall_irq_on & ~out_next & out_reg;
      flag_clear = do_write && w_lane_reg &&
                   w_byte_reg[clc_pkg::STATUS_FLAG_BIT] &&
                   {aw_addr_reg[7:2], 2'b00} == clc_pkg::OFF_STATUS;
      // a new edge outweighs a clear in the same cycle
      flag_next = (flag_reg & ~flag_clear) | rise_evt | fall_evt;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flag_reg <= 1'b0;
      end else begin
         flag_reg <= flag_next;
      end
   end

   assign cell_irq_flag = flag_reg;

endmodule

// *** tb/clc_src_model.sv ***
`timescale 1ns/1ns
module clc_src_model (
   input wire logic aclk,
   input wire logic [3:0] drive_bits,
   output logic [63:0] source_in
);
   // ----------------------------------------
   // far-side signal sources
   // ----------------------------------------
   logic [3:0] bits_reg;
   logic [59:0] pat_reg = 60'h0000_0000_0000_000;
   // unused sources toggle each cycle so no select leans on a quiet 0
   always_ff @(posedge aclk) begin
      bits_reg <= drive_bits;
      pat_reg <= ~pat_reg;
   end
   // plain digital levels only, no analog pin in the path
   assign source_in = {pat_reg, bits_reg};
endmodule

// *** tb/clc_cell_checker.sv ***
`timescale 1ns/1ns
module clc_cell_checker (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [clc_pkg::ADDR_W-1:0] araddr,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [clc_pkg::DATA_W-1:0] rdata,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic cell_output_signal,
   input wire logic cell_irq_flag
);
   // ----------------------------------------
   // address of the read in flight
   // ----------------------------------------
   logic [7:0] ar_addr_reg;
   logic [7:0] ar_addr_next;
   always_comb begin
      ar_addr_next = ar_addr_reg;
      if (arvalid && arready) begin
         ar_addr_next = araddr;
      end
   end
   always_ff @(posedge aclk) begin
      ar_addr_reg <= ar_addr_next;
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   reset_clear_a: assert property ($rose(aresetn)
      |-> !cell_output_signal && !cell_irq_flag) else $error("reset left out");
   flag_clear_a: assert property ($fell(cell_irq_flag)
      && $past(aresetn) |-> $rose(bvalid)) else $error("flag lost");
   flag_cause_a: assert property ($rose(cell_irq_flag)
      |-> $changed(cell_output_signal)) else $error("flag without edge");
   write_hold_a: assert property (bvalid && !bready |=> bvalid)
      else $error("bvalid dropped");
   read_hold_a: assert property (rvalid && !rready
      |=> rvalid && $stable(rdata)) else $error("read data moved");
   // write lands one edge after the take, bvalid is seen the edge after
   write_answer_a: assert property (awvalid && awready && wvalid
      && wready |-> ##2 bvalid) else $error("no write answer");
   read_answer_a: assert property (arvalid && arready |=> rvalid)
      else $error("no read answer");
   busy_refuse_a: assert property (bvalid |-> !awready && !wready)
      else $error("write taken while busy");
   ctrl_bit5_a: assert property ($rose(rvalid)
      && ar_addr_reg == clc_pkg::OFF_CONTROL
      |-> rdata[5] == $past(cell_output_signal) && !rdata[6])
      else $error("control bit 5 wrong");
   src_zero_a: assert property (rvalid && ar_addr_reg >= 8'h08
      && ar_addr_reg <= 8'h14 |-> rdata[31:6] == 26'h000_0000)
      else $error("select upper bits set");
endmodule
bind clc_cell clc_cell_checker chk (.aclk(aclk), .aresetn(aresetn),
   .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
   .wready(wready), .bvalid(bvalid), .bready(bready), .araddr(araddr),
   .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid),
   .rready(rready), .cell_output_signal(cell_output_signal),
   .cell_irq_flag(cell_irq_flag));

// *** tb/test_configurable_logic_cell.sv ***
`timescale 1ns/1ns
module test_configurable_logic_cell;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, out, flag;
   logic [clc_pkg::ADDR_W-1:0] awaddr, araddr;
   logic [clc_pkg::DATA_W-1:0] wdata, rdata, rd_data;
   logic [3:0] wstrb, drive_bits;
   logic [1:0] bresp, rresp, rd_resp, wr_resp;
   logic [63:0] source_in;
   logic [15:0] tab [0:22];
   int failures, samples_checked, cycles;
   clc_src_model src (.aclk(aclk), .drive_bits(drive_bits),
      .source_in(source_in));
   clc_cell dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .source_in(source_in), .cell_output_signal(out),
      .cell_irq_flag(flag));
   // ----------------------------------------
   // bus tasks and checks
   // ----------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'h0;
         if (wvalid && wready) wvalid <= 1'h0;
      end while (bvalid !== 1'h1);
      // bready stays high: no drop and rise in one time step
      wr_resp = bresp;
   endtask
   task automatic rd(input logic [7:0] a);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'h0;
      end while (rvalid !== 1'h1);
      rd_data = rdata;
      rd_resp = rresp;
   endtask
   task automatic chk(input string n, input logic [31:0] s, e);
      samples_checked++;
      if (s !== e) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic rdc(input string n, input logic [7:0] a,
      input logic [7:0] e);
      rd(a);
      chk(n, rd_data, {24'h00_0000, e});
   endtask
   task automatic ck1(input string n, input logic s, input logic e);
      chk(n, {31'h0000_0000, s}, {31'h0000_0000, e});
   endtask
   // fixed wait: sampling stage plus sync stages plus output register
   task automatic settle;
      repeat (6) @(posedge aclk);
   endtask
   function automatic logic fexp(input int m, input logic [3:0] g);
      case (m)
         0: fexp = (g[0] & g[1]) | (g[2] & g[3]);
         1: fexp = (g[0] | g[1]) ^ (g[2] | g[3]);
         default: fexp = &g;
      endcase
   endfunction
   task close_out;
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      aclk = 1'h0;
      forever #25 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         close_out();
      end
   end
   // ----------------------------------------
   // sequence: mode, polarity, expected output
   // ----------------------------------------
   initial begin
      tab = '{16'h4040, 16'h4020, 16'h4031, 16'h4011, 16'h4050,
         16'h7021, 16'h7031, 16'h7011, 16'h7000, 16'h6040, 16'h6020,
         16'h6031, 16'h60A1, 16'h60B0, 16'h5040, 16'h50A0, 16'h50B1,
         16'h3040, 16'h3000, 16'h3011, 16'h3001, 16'h3051, 16'h3040};
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
      {awaddr, araddr, wdata, drive_bits} = 52'h0_0000_0000_0000;
      wstrb = 4'hF;
      repeat (20) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      rdc("control", clc_pkg::OFF_CONTROL, 8'h00);
      rd(8'h2C);
      chk("unmapped", {30'h0000_0000, rd_resp}, 32'h0000_0002);
      wr(8'h2C, 32'h0000_0000);
      chk("unmapped wr", {30'h0000_0000, wr_resp}, 32'h0000_0002);
      wr(clc_pkg::OFF_CONTROL, 32'h0000_0000);
      chk("write resp", {30'h0000_0000, wr_resp}, 32'h0000_0000);
      for (int i = 0; i < 4; i++) begin
         wr(clc_pkg::OFF_SRC1 + 8'(4 * i), 32'(i) | 32'h0000_00C0);
         wr(clc_pkg::OFF_GATE1 + 8'(4 * i), (i == 0) ? 32'h2 : 32'h0);
      end
      wr(clc_pkg::OFF_POLARITY, 32'h0000_0072);
      rdc("polarity", clc_pkg::OFF_POLARITY, 8'h02);
      for (int i = 0; i < 4; i++) begin
         rdc("select", clc_pkg::OFF_SRC1 + 8'(4 * i), 8'(i));
      end
      rdc("gate", clc_pkg::OFF_GATE1, 8'h02);
      wr(clc_pkg::OFF_CONTROL, 32'h0000_0090);
      drive_bits <= 4'h1;
      settle();
      ck1("output", out, 1'h1);
      ck1("flag", flag, 1'h1);
      rdc("control", clc_pkg::OFF_CONTROL, 8'hB0);
      wr(clc_pkg::OFF_STATUS, 32'h0000_0001);
      ck1("flag", flag, 1'h0);
      drive_bits <= 4'h0;
      settle();
      ck1("flag", flag, 1'h0);
      wr(clc_pkg::OFF_CONTROL, 32'h0000_00A8);
      rdc("control", clc_pkg::OFF_CONTROL, 8'h88);
      drive_bits <= 4'h1;
      settle();
      ck1("flag", flag, 1'h0);
      drive_bits <= 4'h0;
      settle();
      rdc("status", clc_pkg::OFF_STATUS, 8'h01);
      wr(clc_pkg::OFF_GATE1, 32'h0000_0001);
      settle();
      ck1("output", out, 1'h1);
      wr(clc_pkg::OFF_POLARITY, 32'h0000_0082);
      settle();
      ck1("output", out, 1'h0);
      // gate 2 plain: result low, inverted high, so disabling shows
      wr(clc_pkg::OFF_POLARITY, 32'h0000_0080);
      settle();
      ck1("output", out, 1'h1);
      wr(clc_pkg::OFF_CONTROL, 32'h0000_0000);
      settle();
      ck1("output", out, 1'h0);
      wr(clc_pkg::OFF_GATE1, 32'h0000_0000);
      for (int m = 0; m < 3; m++) begin
         wr(clc_pkg::OFF_CONTROL, 32'h0000_0080 | 32'(m));
         for (int g = 0; g < 16; g++) begin
            wr(clc_pkg::OFF_POLARITY, 32'(g));
            settle();
            ck1("combine", out, fexp(m, 4'(g)));
         end
      end
      for (int k = 0; k < 23; k++) begin
         wr(clc_pkg::OFF_CONTROL, 32'h80 | 32'(tab[k][15:12]));
         wr(clc_pkg::OFF_POLARITY, 32'(tab[k][11:4]));
         settle();
         ck1("stateful", out, tab[k][0]);
      end
      wr(clc_pkg::OFF_GATE2, 32'h0000_005A);
      wr(clc_pkg::OFF_POLARITY, 32'h0000_008B);
      aresetn <= 1'h0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      rdc("control", clc_pkg::OFF_CONTROL, 8'h00);
      rdc("gate", clc_pkg::OFF_GATE2, 8'h5A);
      rdc("polarity", clc_pkg::OFF_POLARITY, 8'h0B);
      close_out();
   end
endmodule
